// >>> rtl/fcl_pkg.sv
package fcl_pkg;

	// ==================================================================
	// fuse byte offsets
	localparam logic [3:0] FCL_OFS_WDT = 4'h0;
	localparam logic [3:0] FCL_OFS_BOD = 4'h1;
	localparam logic [3:0] FCL_OFS_OSC = 4'h2;
	localparam logic [3:0] FCL_OFS_SYS0 = 4'h5;
	localparam logic [3:0] FCL_OFS_SYS1 = 4'h6;
	localparam logic [3:0] FCL_OFS_CODE = 4'h7;
	localparam logic [3:0] FCL_OFS_BOOT = 4'h8;
	localparam logic [3:0] FCL_OFS_HOLE_LO = 4'h3;
	localparam logic [3:0] FCL_OFS_HOLE_HI = 4'h4;
	localparam int FCL_NUM_FUSES = 9;

	// ==================================================================
	// field positions (low bit of each field)
	localparam int FCL_WDT_WINDOW_LSB = 4;
	localparam int FCL_WDT_PERIOD_LSB = 0;
	localparam int FCL_BOD_LEVEL_LSB = 5;
	localparam int FCL_BOD_RATE_BIT = 4;
	localparam int FCL_BOD_ACTIVE_LSB = 2;
	localparam int FCL_BOD_SLEEP_LSB = 0;
	localparam int FCL_OSC_SEL_LSB = 0;
	localparam int FCL_SYS0_REGION_LSB = 6;
	localparam int FCL_SYS0_POLY_BIT = 5;
	localparam int FCL_SYS0_DEBUG_BIT = 4;

	// ==================================================================
	// reserved-bit masks: set bits are kept, clear bits read as zero
	localparam logic [7:0] FCL_MASK_OSC = 8'h0f;
	localparam logic [7:0] FCL_MASK_SYS0 = 8'hf9;
	localparam logic [7:0] FCL_MASK_SYS1 = 8'h1f;

	// ==================================================================
	// field encodings
	localparam logic [2:0] FCL_LEVEL_MAX = 3'h3;
	localparam logic [1:0] FCL_MODE_OFF = 2'h0;
	localparam logic [1:0] FCL_MODE_WAIT = 2'h3;
	localparam logic [1:0] FCL_SLEEP_RSVD = 2'h3;
	localparam logic [3:0] FCL_OSC_FAST = 4'h0;
	localparam logic [3:0] FCL_OSC_SLOW = 4'h1;
	localparam logic [1:0] FCL_REGION_NONE = 2'h3;

	// ==================================================================
	// reset values of the target fields
	localparam logic [7:0] FCL_RST_BYTE = 8'h00;

	// ==================================================================
	// timing counts
	// edges after a wake during which the synchronised status is stale
	localparam logic [1:0] FCL_WAKE_BLANK = 2'h2;

	typedef enum logic [1:0] {
		FCL_ST_RESET = 2'b00,
		FCL_ST_FETCH = 2'b01,
		FCL_ST_APPLY = 2'b11,
		FCL_ST_RUN = 2'b10
	} fcl_state_e;

endpackage

// >>> rtl/fcl_fuse_array.sv
// ======================================================================
// nonvolatile fuse bytes: written only from the programming port
module fcl_fuse_array
	import fcl_pkg::*;
#(
	parameter int NUM = FCL_NUM_FUSES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic prog_we,
	input wire logic [3:0] prog_addr,
	input wire logic [7:0] prog_wdata,
	input wire logic [3:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem_q [NUM];
	logic [7:0] mem_d [NUM];

	// reserved bits are kept zero whatever the programmer sends
	function automatic logic [7:0] fcl_mask(input logic [3:0] a);
		unique case (a)
			FCL_OFS_OSC: fcl_mask = FCL_MASK_OSC;
			FCL_OFS_SYS0: fcl_mask = FCL_MASK_SYS0;
			FCL_OFS_SYS1: fcl_mask = FCL_MASK_SYS1;
			default: fcl_mask = 8'hff;
		endcase
	endfunction

	// holes are never written and offsets past the last byte hold no storage
	function automatic logic fcl_mapped(input logic [3:0] a);
		fcl_mapped = (int'(a) < NUM) && (a != FCL_OFS_HOLE_LO) &&
			(a != FCL_OFS_HOLE_HI);
	endfunction

	// next contents; holes are never written
	always_comb begin
		for (int i = 0; i < NUM; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (prog_we && fcl_mapped(prog_addr)) begin
			mem_d[prog_addr] = prog_wdata & fcl_mask(prog_addr); // RULE13
		end
	end

	// contents survive reset: nonvolatile, so srst is not used here
	always_ff @(posedge clk) begin
		if (clk_en) begin
			mem_q <= mem_d;
		end
	end

	// combinational read; holes and unmapped offsets read zero, since
	// their never-written storage would otherwise leak unknowns
	always_comb begin
		if (fcl_mapped(rd_addr)) begin
			rd_data = mem_q[rd_addr];
		end else begin
			rd_data = FCL_RST_BYTE;
		end
	end

endmodule

// >>> rtl/fcl_loader.sv
// How it works
// RULE1 - watchdog fuse bits 7:4 go to the window field at reset.
// RULE2 - watchdog fuse bits 3:0 go to the period field at reset.
// RULE3 - brown-out bits 7:5 set threshold level; codes above 3 reserved.
// RULE4 - brown-out bit 4 sets sample rate: 0 is 128 Hz, 1 is 32 Hz.
// RULE5 - brown-out bits 3:2 set active mode: off, on, sampled, on-with-wait.
// RULE6 - active mode 3 holds execution at wake until detector runs.
// RULE7 - brown-out bits 1:0 set sleep mode; code 3 reserved.
// RULE8 - oscillator bits 3:0 pick default clock: 0 fast, 1 slow.
// RULE9 - system bits 7:6 choose the region scanned at reset.
// RULE10 - system bit 5 chooses CRC-16-CCITT or CRC-32 polynomial.
// RULE11 - system bit 4 makes debug pin GPIO or debug with pull-up.
// RULE12 - fuses copy out at end of start-up; changes need reset.
// RULE13 - CPU and debug read fuses; only programmer writes, reserved zero.
module fcl_loader
	import fcl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic startup_done,
	input wire logic prog_we,
	input wire logic [3:0] prog_addr,
	input wire logic [7:0] prog_wdata,
	input wire logic [3:0] cpu_addr,
	output logic [7:0] cpu_rdata,
	input wire logic wake_event,
	input wire logic bod_running,
	output logic load_busy,
	output logic [3:0] watchdog_window,
	output logic [3:0] watchdog_period,
	output logic [2:0] threshold_level,
	output logic threshold_reserved,
	output logic sample_rate_select,
	output logic [1:0] bod_active_mode,
	output logic [1:0] bod_sleep_mode,
	output logic sleep_mode_reserved,
	output logic cpu_hold,
	output logic [3:0] clock_source_code,
	output logic use_internal_slow_oscillator,
	output logic clock_code_reserved,
	output logic [1:0] scan_region_select,
	output logic scan_enable,
	output logic polynomial_select,
	output logic debug_pin_function,
	output logic debug_pin_pullup
);

	// ==================================================================
	// fuse storage and address sharing
	logic [3:0] rd_addr;
	logic [7:0] rd_data;
	fcl_state_e st_q;
	fcl_state_e st_d;
	logic [3:0] idx_q;
	logic [3:0] idx_d;

	// loader owns the read port while copying; cpu sees zero meanwhile
	assign rd_addr = (st_q == FCL_ST_FETCH) ? idx_q : cpu_addr;
	assign cpu_rdata = (st_q == FCL_ST_FETCH) ? FCL_RST_BYTE : rd_data; // RULE13

	fcl_fuse_array #(
		.NUM(FCL_NUM_FUSES)
	) u_fuses (
		.clk(clk),
		.srst(srst),
		.clk_en(clk_en),
		.prog_we(prog_we), // RULE13
		.prog_addr(prog_addr),
		.prog_wdata(prog_wdata),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// ==================================================================
	// load sequencer
	// copies happen once per reset, so later fuse writes wait for reset
	// the walk reads one byte per edge: watchdog, brown-out, oscillator,
	// the two holes, then the system byte; the holes cost two idle edges
	// but keep the index a plain counter
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		unique case (st_q)
			FCL_ST_RESET: begin
				idx_d = FCL_OFS_WDT;
				if (startup_done) begin
					st_d = FCL_ST_FETCH; // RULE12
				end
			end
			FCL_ST_FETCH: begin
				if (idx_q == FCL_OFS_SYS0) begin
					st_d = FCL_ST_APPLY;
				end else begin
					idx_d = idx_q + 4'h1;
				end
			end
			FCL_ST_APPLY: st_d = FCL_ST_RUN;
			FCL_ST_RUN: st_d = FCL_ST_RUN; // RULE12
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= FCL_ST_RESET;
			idx_q <= 4'h0;
		end else if (clk_en) begin
			st_q <= st_d;
			idx_q <= idx_d;
		end
	end

	assign load_busy = (st_q != FCL_ST_RUN);

	// ==================================================================
	// shadow copies of the fuse bytes that feed targets
	logic [7:0] wdt_q;
	logic [7:0] wdt_d;
	logic [7:0] bod_q;
	logic [7:0] bod_d;
	logic [7:0] osc_q;
	logic [7:0] osc_d;
	logic [7:0] sys_q;
	logic [7:0] sys_d;

	// capture each byte as the sequencer walks past it
	always_comb begin
		wdt_d = wdt_q;
		bod_d = bod_q;
		osc_d = osc_q;
		sys_d = sys_q;
		if (st_q == FCL_ST_FETCH) begin
			unique case (idx_q)
				FCL_OFS_WDT: wdt_d = rd_data; // RULE1 RULE2
				FCL_OFS_BOD: bod_d = rd_data; // RULE3
				FCL_OFS_OSC: osc_d = rd_data; // RULE8
				FCL_OFS_SYS0: sys_d = rd_data; // RULE9
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wdt_q <= FCL_RST_BYTE;
			bod_q <= FCL_RST_BYTE;
			osc_q <= FCL_RST_BYTE;
			sys_q <= FCL_RST_BYTE;
		end else if (clk_en) begin
			wdt_q <= wdt_d;
			bod_q <= bod_d;
			osc_q <= osc_d;
			sys_q <= sys_d;
		end
	end

	// ==================================================================
	// target fields, updated together at the apply step
	logic [7:0] t_wdt_q;
	logic [7:0] t_wdt_d;
	logic [7:0] t_bod_q;
	logic [7:0] t_bod_d;
	logic [3:0] t_osc_q;
	logic [3:0] t_osc_d;
	logic [3:0] t_sys_q;
	logic [3:0] t_sys_d;

	// targets keep safe zero defaults until the fuses arrive
	always_comb begin
		t_wdt_d = t_wdt_q;
		t_bod_d = t_bod_q;
		t_osc_d = t_osc_q;
		t_sys_d = t_sys_q;
		if (st_q == FCL_ST_APPLY) begin
			t_wdt_d = wdt_q; // RULE1 RULE2
			t_bod_d = bod_q; // RULE3 RULE4 RULE5 RULE7
			t_osc_d = osc_q[FCL_OSC_SEL_LSB +: 4]; // RULE8
			t_sys_d = sys_q[FCL_SYS0_DEBUG_BIT +: 4]; // RULE9 RULE10 RULE11
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			t_wdt_q <= FCL_RST_BYTE;
			t_bod_q <= FCL_RST_BYTE;
			t_osc_q <= 4'h0;
			t_sys_q <= 4'h0;
		end else if (clk_en) begin
			t_wdt_q <= t_wdt_d;
			t_bod_q <= t_bod_d;
			t_osc_q <= t_osc_d;
			t_sys_q <= t_sys_d;
		end
	end

	// watchdog fields
	assign watchdog_window = t_wdt_q[FCL_WDT_WINDOW_LSB +: 4]; // RULE1
	assign watchdog_period = t_wdt_q[FCL_WDT_PERIOD_LSB +: 4]; // RULE2

	// brown-out fields; reserved codes are flagged, not altered
	assign threshold_level = t_bod_q[FCL_BOD_LEVEL_LSB +: 3]; // RULE3
	assign threshold_reserved = threshold_level > FCL_LEVEL_MAX; // RULE3
	assign sample_rate_select = t_bod_q[FCL_BOD_RATE_BIT]; // RULE4
	assign bod_active_mode = t_bod_q[FCL_BOD_ACTIVE_LSB +: 2]; // RULE5
	assign bod_sleep_mode = t_bod_q[FCL_BOD_SLEEP_LSB +: 2]; // RULE7
	assign sleep_mode_reserved = bod_sleep_mode == FCL_SLEEP_RSVD; // RULE7

	// clock default
	assign clock_source_code = t_osc_q; // RULE8
	assign use_internal_slow_oscillator = t_osc_q == FCL_OSC_SLOW; // RULE8
	assign clock_code_reserved = (t_osc_q != FCL_OSC_FAST) &&
		(t_osc_q != FCL_OSC_SLOW); // RULE8

	// scan and debug pin: t_sys_q holds system byte bits 7:4
	localparam int SYS_DEBUG = 0;
	localparam int SYS_POLY = FCL_SYS0_POLY_BIT - FCL_SYS0_DEBUG_BIT;
	localparam int SYS_REGION = FCL_SYS0_REGION_LSB - FCL_SYS0_DEBUG_BIT;

	// the debug bit drives both the pin function and its pull-up
	function automatic logic sys_bit_debug(input logic [3:0] f);
		sys_bit_debug = f[SYS_DEBUG];
	endfunction

	assign scan_region_select = t_sys_q[SYS_REGION +: 2]; // RULE9
	assign scan_enable = !load_busy &&
		(scan_region_select != FCL_REGION_NONE); // RULE9
	assign polynomial_select = t_sys_q[SYS_POLY]; // RULE10
	assign debug_pin_function = sys_bit_debug(t_sys_q); // RULE11
	assign debug_pin_pullup = sys_bit_debug(t_sys_q); // RULE11

	// ==================================================================
	// wake hold: cpu waits at wake until the detector reports running
	logic hold_q;
	logic hold_d;
	logic [1:0] blank_q;
	logic [1:0] blank_d;
	logic run_s1_q;
	logic run_s2_q;
	logic hold_arm;
	logic run_seen;

	// detector status comes from another domain, so synchronise it
	always_ff @(posedge clk) begin
		if (srst) begin
			run_s1_q <= 1'b0;
			run_s2_q <= 1'b0;
		end else if (clk_en) begin
			run_s1_q <= bod_running;
			run_s2_q <= run_s1_q;
		end
	end

	// a wake arms the hold only when the applied mode asks for it
	assign hold_arm = wake_event && !load_busy &&
		(bod_active_mode == FCL_MODE_WAIT); // RULE6

	// the synchroniser still carries the status from before the wake,
	// so running is trusted only once the blanking count has run out
	assign run_seen = run_s2_q && (blank_q == 2'h0); // RULE6

	// set beats clear when a new wake lands on the releasing cycle
	always_comb begin
		hold_d = hold_q;
		blank_d = blank_q;
		if (blank_q != 2'h0) begin
			blank_d = blank_q - 2'h1;
		end
		if (hold_arm) begin
			hold_d = 1'b1; // RULE6
			blank_d = FCL_WAKE_BLANK;
		end else if (run_seen) begin
			hold_d = 1'b0; // RULE6
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hold_q <= 1'b0;
			blank_q <= 2'h0;
		end else if (clk_en) begin
			hold_q <= hold_d;
			blank_q <= blank_d;
		end
	end

	// execution is also held until the fuses have been applied
	assign cpu_hold = hold_q || load_busy; // RULE6 RULE12

endmodule

// >>> sim/fcl_bod_model.sv
// ==========
// brown-out detector stand-in
module fcl_bod_model #(
	parameter int SETTLE = 9
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic slow,
	input wire logic wake_event,
	output logic bod_running
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	int cnt_d;
	// a wake restarts the detector; slow mode takes longer to settle
	always_comb begin
		cnt_d = cnt_q;
		if (wake_event) cnt_d = slow ? SETTLE : 1;
		else if (cnt_q > 0) cnt_d = cnt_q - 1;
	end
	always_ff @(posedge clk) begin
		if (srst) cnt_q <= 0;
		else cnt_q <= cnt_d;
	end
	assign bod_running = (cnt_q == 0);
endmodule

// >>> sim/fcl_loader_monitor.sv
module fcl_loader_monitor
	import fcl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic startup_done,
	input wire logic wake_event,
	input wire logic bod_running,
	input wire logic load_busy,
	input wire logic cpu_hold,
	input wire logic [3:0] watchdog_window,
	input wire logic [2:0] threshold_level,
	input wire logic threshold_reserved,
	input wire logic [1:0] bod_active_mode,
	input wire logic [1:0] bod_sleep_mode,
	input wire logic sleep_mode_reserved,
	input wire logic [1:0] scan_region_select,
	input wire logic scan_enable
);
	// ==========
	// copy timing
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// entry edge, six fetch edges, then the apply edge
	sequence s_go;
		$fell(srst) && startup_done ##0 (clk_en && startup_done)[*8];
	endsequence
	property p_done;
		s_go |=> !load_busy;
	endproperty
	a_done: assert property (p_done) else $error("copy late");
	property p_busy;
		$fell(srst) |-> load_busy[*8];
	endproperty
	a_busy: assert property (p_busy) else $error("copy early");
	// the watchdog window must ignore fuse writes until the next reset
	property p_stand;
		!load_busy ##1 !load_busy |-> $stable(watchdog_window);
	endproperty
	a_stand: assert property (p_stand) else $error("moved");
	// ==========
	// decoded flags
	property p_thr;
		threshold_reserved == (threshold_level > FCL_LEVEL_MAX);
	endproperty
	a_thr: assert property (p_thr) else $error("level flag");
	property p_sleep;
		sleep_mode_reserved == (bod_sleep_mode == FCL_SLEEP_RSVD);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flag");
	property p_scan;
		scan_enable == (!load_busy && scan_region_select != FCL_REGION_NONE);
	endproperty
	a_scan: assert property (p_scan) else $error("scan enable");
	// ==========
	// wake hold
	property p_wake;
		wake_event && bod_active_mode == FCL_MODE_WAIT |=> cpu_hold;
	endproperty
	a_wake: assert property (p_wake) else $error("no hold");
	// the hold must outlast the stale status left in the synchroniser
	sequence s_arm;
		wake_event && bod_active_mode == FCL_MODE_WAIT && !load_busy;
	endsequence
	property p_blank;
		s_arm |=> cpu_hold[*3];
	endproperty
	a_blank: assert property (p_blank) else $error("short hold");
	property p_clear;
		(bod_running && !wake_event && !load_busy)[*4] |=> !cpu_hold;
	endproperty
	a_clear: assert property (p_clear) else $error("hold stuck");
endmodule
bind fcl_loader fcl_loader_monitor fcl_loader_monitor_i (.*);

// >>> sim/fcl_loader_test.sv
module fcl_loader_test
	import fcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic startup_done = 1'b0;
	logic prog_we = 1'b0;
	logic [3:0] prog_addr = 4'h0;
	logic [7:0] prog_wdata = 8'h00;
	logic [3:0] cpu_addr = 4'h0;
	logic wake_event = 1'b0;
	logic slow = 1'b0;
	logic [7:0] cpu_rdata;
	logic [3:0] watchdog_window, watchdog_period, clock_source_code;
	logic [2:0] threshold_level;
	logic [1:0] bod_active_mode, bod_sleep_mode, scan_region_select;
	logic bod_running, load_busy, threshold_reserved, sample_rate_select;
	logic sleep_mode_reserved, cpu_hold, use_internal_slow_oscillator;
	logic clock_code_reserved, scan_enable, polynomial_select;
	logic debug_pin_function, debug_pin_pullup;
	logic [31:0] tgt;
	int fail_count = 0;
	int num_checks = 0;
	fcl_loader fcl_loader_i (.*);
	fcl_bod_model fcl_bod_model_i (.*);
	// all target fields packed, so two compares cover a whole load
	assign tgt = {2'h0, watchdog_window, watchdog_period, threshold_level,
		threshold_reserved, sample_rate_select, bod_active_mode,
		bod_sleep_mode, sleep_mode_reserved, clock_source_code,
		use_internal_slow_oscillator, clock_code_reserved,
		scan_region_select, scan_enable, polynomial_select,
		debug_pin_function, debug_pin_pullup};
	initial begin
		forever #20 clk = ~clk;
	end
	// ==========
	// helpers
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic fw(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		prog_we <= 1'b1;
		prog_addr <= a;
		prog_wdata <= d;
		@(posedge clk);
		prog_we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		cpu_addr <= a;
		@(negedge clk);
		chk(32'(cpu_rdata), 32'(e));
	endtask
	// bounded wait for load_busy or, with sel set, cpu_hold to drop
	task automatic wait_low(input bit sel);
		int n;
		for (n = 0; n < 40 && (sel ? cpu_hold : load_busy) !== 1'b0; n++)
			@(negedge clk);
		if (n == 40) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	// ==========
	// scenarios
	// reset and copy; reads are blanked while bytes are fetched
	task automatic load();
		@(posedge clk);
		srst <= 1'b1;
		startup_done <= 1'b1;
		cpu_addr <= FCL_OFS_WDT;
		@(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk(tgt, 32'h0);
		@(negedge clk);
		chk(32'(cpu_rdata), 32'h0);
		wait_low(1'b0);
	endtask
	task automatic wake(input logic hold);
		@(posedge clk);
		wake_event <= 1'b1;
		slow <= ~slow;
		@(posedge clk);
		wake_event <= 1'b0;
		@(negedge clk);
		chk(32'(cpu_hold), 32'(hold));
		wait_low(1'b1);
		if (hold) chk(32'(bod_running), 32'h1);
	endtask
	// five passes writing one code per field, reserved fuse bits written as ones on purpose
	task automatic codes();
		logic [7:0] w, b, o, s;
		logic [31:0] e;
		for (int i = 0; i < 5; i++) begin
			w = {4'(i + 10), 4'(i + 3)};
			b = {3'(i), i[0], 2'(i), 2'(i)};
			o = 8'(i) | 8'hf0;
			s = {2'(i), i[0], i[1], 4'hf};
			fw(FCL_OFS_WDT, w);
			fw(FCL_OFS_BOD, b);
			fw(FCL_OFS_OSC, o);
			fw(FCL_OFS_SYS0, s);
			load();
			e = {2'h0, w, b[7:5], b[7:5] > FCL_LEVEL_MAX, b[4], b[3:2],
				b[1:0], b[1:0] == FCL_SLEEP_RSVD, o[3:0],
				o[3:0] == FCL_OSC_SLOW, o[3:0] > FCL_OSC_SLOW, s[7:6],
				s[7:6] != FCL_REGION_NONE, s[5], s[4], s[4]};
			chk(32'(tgt[31:15]), 32'(e[31:15]));
			chk(32'(tgt[14:0]), 32'(e[14:0]));
			rd(FCL_OFS_OSC, o & 8'h0f);
			rd(FCL_OFS_SYS0, s & 8'hf9);
			repeat (2) wake(b[3:2] == FCL_MODE_WAIT);
		end
	endtask
	// a rewrite waits for reset; holes and unmapped places read zero
	task automatic stand();
		fw(FCL_OFS_WDT, 8'h5a);
		fw(4'h3, 8'hff);
		chk(32'(watchdog_window), 32'he);
		rd(FCL_OFS_WDT, 8'h5a);
		rd(4'h3, 8'h00);
		rd(4'h9, 8'h00);
		rd(FCL_OFS_SYS1, 8'h06);
		rd(FCL_OFS_BOOT, 8'h88);
		load();
		chk(32'(watchdog_window), 32'h5);
	endtask
	// clock enable low freezes everything, fuse bytes included
	task automatic freeze();
		@(posedge clk);
		clk_en <= 1'b0;
		fw(FCL_OFS_CODE, 8'h3c);
		rd(FCL_OFS_CODE, 8'h77);
		chk(32'(watchdog_window), 32'h5);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(FCL_OFS_CODE, 8'h77);
	endtask
	initial begin
		for (int a = 0; a < 9; a++) fw(4'(a), 8'(a * 17));
		repeat (2) @(posedge clk);
		codes();
		stand();
		freeze();
		report_and_stop();
	end
endmodule
